// ### design/aca_top.sv
// Clock alignment control with AXI4-Lite register access
//
// Notes on behaviour
// - Internal align signal outlasts the pulse by 0 to 15 cycles.
// - Hold select low: internal clocks frozen while align is asserted.
// - Hold select high: clocks keep toggling, realigned at align fall.
// - Other setting changes apply at once without a pulse.
// - Test resources reinitialised on a pulse after test entry only.
// - Decimation dividers reset by align; data flagged stale meanwhile.
// - Align realigns all four data-valid clocks to a known phase.
// - Hold select resets to frozen-clocks behaviour.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module aca_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic align_pulse_pos,
  input wire logic align_pulse_neg,
  output aca_pkg::aca_ctrl_t mode_out,
  output aca_pkg::aca_out_t clk_out
);
  import aca_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [ACA_CTRL_W-1:0] ctrl_reg;
  logic [3:0] ext_reg;
  logic aw_held_reg, w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic align_reg;
  logic test_pend_reg;
  logic [7:0] init_cnt_reg;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ACA_CTRL_ADDR) || (a == ACA_EXT_ADDR) ||
               (a == ACA_STAT_ADDR) || (a == ACA_ID_ADDR);
  endfunction : addr_hit

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic aw_now, w_now, do_write;
  assign aw_now = aw_held_reg || (s_axi_awvalid && s_axi_awready);
  assign w_now = w_held_reg || (s_axi_wvalid && s_axi_wready);
  assign do_write = aw_now && w_now && !s_axi_bvalid;
  assign wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wd = w_held_reg ? wdata_reg : s_axi_wdata;
  assign ws = w_held_reg ? wstrb_reg : s_axi_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          awaddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          wdata_reg <= s_axi_wdata;
          wstrb_reg <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACA_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_hit(wa) ? ACA_RESP_OKAY : ACA_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Settings apply the cycle after the write; no pulse needed for them
  // immediate settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ACA_CTRL_RST;
      ext_reg <= ACA_EXT_RST;
    end else if (do_write && ws[0]) begin
      if (wa == ACA_CTRL_ADDR) begin
        ctrl_reg <= wd[ACA_CTRL_W-1:0];
      end
      if (wa == ACA_EXT_ADDR) begin
        ext_reg <= wd[3:0];
      end
    end
  end

  logic [31:0] rd;
  always_comb begin
    case (s_axi_araddr)
      ACA_CTRL_ADDR: rd = {24'h00_0000, ctrl_reg};
      ACA_EXT_ADDR: rd = {28'h000_0000, ext_reg};
      ACA_STAT_ADDR: rd = {29'h0000_0000, test_pend_reg, clk_out.sample_clk_en, align_reg};
      ACA_ID_ADDR: rd = {16'h0000, ACA_ID_VALUE};
      default: rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ACA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= addr_hit(s_axi_araddr) ? ACA_RESP_OKAY : ACA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Alignment pulse capture and stretch
  // ----------------------------------------
  logic sync1_reg, sync2_reg, sync3_reg;
  logic [3:0] stretch_reg;
  logic pulse_in;
  // width and quiet window are host duties; pulse read differentially
  assign pulse_in = align_pulse_pos & ~align_pulse_neg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= pulse_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic fall;
  assign fall = sync3_reg && !sync2_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_reg <= 1'b0;
      stretch_reg <= 4'h0;
    end else if (sync2_reg) begin
      align_reg <= 1'b1;
      stretch_reg <= 4'h0;
    end else if (fall) begin
      align_reg <= (ext_reg != 4'h0);
      stretch_reg <= ext_reg;
    end else if (stretch_reg != 4'h0) begin
      stretch_reg <= stretch_reg - 4'h1;
      align_reg <= (stretch_reg != 4'h1);
    end else begin
      align_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Internal clocks
  // ----------------------------------------
  logic [ACA_DIV_W-1:0] div_reg;
  logic align_d_reg;
  logic realign;
  assign realign = align_d_reg && !align_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_d_reg <= 1'b0;
    end else begin
      align_d_reg <= align_reg;
    end
  end

  // frozen during align when hold select low
  // free running, phase reset at align fall when high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else if (!ctrl_reg[ACA_CTRL_HOLD_BIT] && align_reg) begin
      div_reg <= '0;
    end else if (realign) begin
      // Both modes resume from the same phase once align ends
      div_reg <= {{(ACA_DIV_W-1){1'b0}}, 1'b1};
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // test init only on a pulse after test entry
  logic test_d_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_d_reg <= 1'b0;
      test_pend_reg <= 1'b0;
    end else begin
      test_d_reg <= ctrl_reg[ACA_CTRL_TEST_BIT];
      if (!ctrl_reg[ACA_CTRL_TEST_BIT]) begin
        test_pend_reg <= 1'b0;
      end else if (ctrl_reg[ACA_CTRL_TEST_BIT] && !test_d_reg) begin
        test_pend_reg <= 1'b1;
      end else if (realign) begin
        test_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out.sample_clk_en <= 1'b1;
      clk_out.data_valid_clk <= '0;
      clk_out.decim_div_clr <= 1'b0;
      clk_out.test_init <= 1'b0;
      clk_out.data_stale <= 1'b0;
      mode_out <= '0;
    end else begin
      clk_out.sample_clk_en <= ctrl_reg[ACA_CTRL_HOLD_BIT] || !align_reg;
      // all data-valid clocks share one reset phase
      clk_out.data_valid_clk <= {ACA_NCH{div_reg[0]}};
      clk_out.decim_div_clr <= ctrl_reg[ACA_CTRL_DECIM_BIT] && align_reg;
      clk_out.test_init <= test_pend_reg && realign;
      clk_out.data_stale <= ctrl_reg[ACA_CTRL_DECIM_BIT] && align_reg;
      mode_out <= aca_ctrl_t'(ctrl_reg);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_freeze_during_align: assert property (@(posedge aclk) disable iff (!aresetn)
    (align_reg && !ctrl_reg[ACA_CTRL_HOLD_BIT]) |=> !clk_out.sample_clk_en)
    else $error("sample clock not frozen during align");
  chk_run_in_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[ACA_CTRL_HOLD_BIT] |=> clk_out.sample_clk_en)
    else $error("sample clock stopped in hold mode");
  chk_align_follows_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse_in |-> ##3 align_reg)
    else $error("align not raised three cycles after pulse");
  chk_zero_ext_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (fall && ext_reg == 4'h0) |=> !align_reg)
    else $error("align not released with zero extension");
  chk_phase_after_align: assert property (@(posedge aclk) disable iff (!aresetn)
    realign |=> div_reg == 4'h1)
    else $error("divider phase not reset at align end");
  chk_decim_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (align_reg && ctrl_reg[ACA_CTRL_DECIM_BIT]) |=> clk_out.decim_div_clr && clk_out.data_stale)
    else $error("decimation clear missing");
endmodule : aca_top
`default_nettype wire

// ### design/aca_pkg.sv
// Package for the converter clock alignment control block
package aca_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int ACA_ID_IDX = 0;
  localparam int ACA_CTRL_IDX = 1;
  localparam int ACA_EXT_IDX = 2;
  localparam int ACA_STAT_IDX = 3;
  localparam logic [7:0] ACA_ID_ADDR = 8'(ACA_ID_IDX * 4);
  localparam logic [7:0] ACA_CTRL_ADDR = 8'(ACA_CTRL_IDX * 4);
  localparam logic [7:0] ACA_EXT_ADDR = 8'(ACA_EXT_IDX * 4);
  localparam logic [7:0] ACA_STAT_ADDR = 8'(ACA_STAT_IDX * 4);
  // Control field positions
  localparam int ACA_CTRL_HOLD_BIT = 0;
  localparam int ACA_CTRL_STBY_BIT = 1;
  localparam int ACA_CTRL_OUTPUT_DEMUX_MODE_BIT = 2;
  localparam int ACA_CTRL_TEST_BIT = 3;
  localparam int ACA_CTRL_CHM_LSB = 4;
  localparam int ACA_CTRL_DECIM_BIT = 6;
  localparam int ACA_CTRL_GRAY_BIT = 7;
  localparam int ACA_CTRL_W = 8;
  // Reset values: frozen clocks during alignment
  localparam logic [7:0] ACA_CTRL_RST = 8'h00;
  localparam logic [3:0] ACA_EXT_RST = 4'h0;
  // Arbitrary identity value
  localparam logic [15:0] ACA_ID_VALUE = 16'h5AA5;
  localparam logic [1:0] ACA_RESP_OKAY = 2'b00;
  localparam logic [1:0] ACA_RESP_SLVERR = 2'b10;
  localparam int ACA_DIV_W = 4;
  localparam int ACA_NCH = 4;

  typedef struct packed {
    logic gray;
    logic decim;
    logic [1:0] chan_mode;
    logic test_mode;
    logic output_demux_mode;
    logic standby;
    logic hold_sel;
  } aca_ctrl_t;

  typedef struct packed {
    logic sample_clk_en;
    logic [ACA_NCH-1:0] data_valid_clk;
    logic decim_div_clr;
    logic test_init;
    logic data_stale;
  } aca_out_t;
endpackage : aca_pkg

// ### dv/aca_host_model.sv
// Host model that drives the differential alignment pulse
`timescale 1ns/1ps
`default_nettype none
module aca_host_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] width,
  output logic pos,
  output logic neg
);
  logic [7:0] cnt_reg;
  initial begin
    pos = 1'b0;
    cnt_reg = 8'h00;
  end
  always @(posedge aclk) begin
    if (go) begin
      cnt_reg <= width;
      pos <= 1'b1;
    end else if (cnt_reg > 8'h01) begin
      cnt_reg <= cnt_reg - 8'h01;
    end else begin
      pos <= 1'b0;
    end
  end
  assign neg = ~pos;
endmodule : aca_host_model
`default_nettype wire

// ### dv/tb.sv
// Testbench for the clock alignment control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import aca_pkg::*;
  logic aclk, aresetn, go, t1, t2, t3;
  logic [7:0] awaddr, araddr, width;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pos, neg;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] bresp, rresp, rd_r, wr_b;
  logic [3:0] dv, dv1;
  logic [3:0] ext_tab [3] = '{4'h0, 4'h3, 4'hF};
  aca_ctrl_t mode_out;
  aca_out_t clk_out;
  int fails, total_checks, lo, lo0, ti, clr, stl, stk;
  aca_top i_aca_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .align_pulse_pos(pos), .align_pulse_neg(neg),
    .mode_out(mode_out), .clk_out(clk_out));
  aca_host_model i_aca_host_model (.aclk(aclk), .go(go), .width(width), .pos(pos),
    .neg(neg));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task timed_out;
    fails++;
    $display("wrong value at %0t: bus wait timed out", $time);
    report_and_stop();
  endtask : timed_out
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      t1 = awvalid && awready;
      t2 = wvalid && wready;
      t3 = bvalid;
      wr_b = bresp;
      @(posedge aclk);
      if (t1) awvalid <= 1'b0;
      if (t2) wvalid <= 1'b0;
      if (t3) begin
        bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    timed_out();
  endtask : wr
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      t1 = arvalid && arready;
      t3 = rvalid;
      rd_v = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (t1) arvalid <= 1'b0;
      if (t3) begin
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    timed_out();
  endtask : rd
  // Sends one pulse and tallies what the block does over a fixed window
  task pulse(input logic [7:0] w);
    go <= 1'b1;
    width <= w;
    @(posedge aclk);
    go <= 1'b0;
    lo = 0;
    ti = 0;
    clr = 0;
    stl = 0;
    stk = 0;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      lo += int'(!clk_out.sample_clk_en);
      ti += int'(clk_out.test_init);
      clr += int'(clk_out.decim_div_clr);
      stl += int'(clk_out.data_stale);
      if (n > 0) stk += int'(clk_out.data_valid_clk == dv);
      dv = clk_out.data_valid_clk;
    end
    @(posedge aclk);
  endtask : pulse
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    {aresetn, go, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    width = 8'h06;
    fails = 0;
    total_checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ACA_CTRL_ADDR);
    chk(rd_v, 32'h0000_0000);
    rd(ACA_ID_ADDR);
    chk(rd_v, 32'(ACA_ID_VALUE));
    rd(8'h10);
    chk(32'(rd_r), 32'(ACA_RESP_SLVERR));
    wr(8'h10, 32'h0000_00FF);
    chk(32'(wr_b), 32'(ACA_RESP_SLVERR));
    rd(ACA_STAT_ADDR);
    chk(rd_v, 32'h0000_0002);
    chk(32'(clk_out.sample_clk_en), 32'h0000_0001);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(ACA_EXT_ADDR, 32'(ext_tab[i]));
      rd(ACA_EXT_ADDR);
      chk(rd_v, 32'(ext_tab[i]));
      pulse(8'h06);
      if (i == 0) lo0 = lo;
      chk(32'(lo - lo0), 32'(ext_tab[i]));
    end
    chk(32'(lo0 > 0), 32'h0000_0001);
    $display("test extension done");
    wr(ACA_EXT_ADDR, 32'h0000_0000);
    chk(32'(wr_b), 32'(ACA_RESP_OKAY));
    wr(ACA_CTRL_ADDR, 32'h0000_0001);
    chk(32'(mode_out), 32'h0000_0001);
    pulse(8'h06);
    chk(32'(lo), 32'h0000_0000);
    chk(32'(stk < 2), 32'h0000_0001);
    $display("test running clocks done");
    wr(ACA_CTRL_ADDR, 32'h0000_0008);
    pulse(8'h06);
    chk(32'(ti), 32'h0000_0001);
    dv1 = dv;
    @(posedge aclk);
    pulse(8'h06);
    chk(32'(ti), 32'h0000_0000);
    chk(32'(dv), 32'(dv1));
    $display("test pattern done");
    wr(ACA_CTRL_ADDR, 32'h0000_0040);
    rd(ACA_CTRL_ADDR);
    chk(rd_v, 32'h0000_0040);
    pulse(8'h06);
    chk(32'(stl > 0), 32'h0000_0001);
    chk(32'(clr > 0), 32'h0000_0001);
    $display("test decimation done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
